//--- verilog/emc_params.svh
`ifndef EMC_PARAMS_SVH
`define EMC_PARAMS_SVH

// Frame size limits in bytes, frame check sequence included
`define EMC_GIANT_STD      16'h05ee
`define EMC_GIANT_VLAN     16'h05f2
`define EMC_GIANT_EXT      16'h07d0
`define EMC_JUMBO_STD      16'h233a
`define EMC_JUMBO_VLAN     16'h233e
`define EMC_RUNT_BYTES     16'h000e
`define EMC_LATE_COL_BYTES 16'h0040
`define EMC_WDOG_STD       16'h0800
`define EMC_WDOG_JUMBO     16'h2800
// Header field values and byte positions
`define EMC_ETYPE_MIN      16'h0600
`define EMC_TPID_VLAN      16'h8100
`define EMC_TYPE_IPV4      16'h0800
`define EMC_LT_POS         16'h000c
`define EMC_VLAN_LT_POS    16'h0010
`define EMC_IP_POS         16'h000e
`define EMC_IP_POS_VLAN    16'h0012
// Line nibbles
`define EMC_NIB_PRE        4'h5
`define EMC_NIB_SFD        4'hd
// Reflected CRC-32, no final inversion in the register
`define EMC_CRC_INIT       32'hffffffff
`define EMC_CRC_POLY       32'hedb88320
`define EMC_CRC_RESIDUE    32'hdebb20e3
// Descriptor word 0 bit positions
`define EMC_B_XST          0
`define EMC_B_CRC          1
`define EMC_B_ODD          2
`define EMC_B_RXER         3
`define EMC_B_RWT          4
`define EMC_B_FT           5
`define EMC_B_LCOL         6
`define EMC_B_GIANT        7
`define EMC_B_LAST         8
`define EMC_B_ES           15
`define EMC_B_AFM          30
// Control register bit positions
`define EMC_C_JUMBO        0
`define EMC_C_EXT2K        1
`define EMC_C_HALF         2
`define EMC_C_NIBBLE       3
`define EMC_C_CSUM1        4
`define EMC_C_XFEAT        5
`define EMC_C_EN           6
// Register offsets and reset values
`define EMC_OFF_CTRL       8'h00
`define EMC_OFF_WORD0      8'h04
`define EMC_OFF_ISTAT      8'h08
`define EMC_OFF_IMASK      8'h0c
`define EMC_OFF_FCNT       8'h10
`define EMC_CTRL_RST       7'h48
`define EMC_IRQ_RST        2'h0
`endif

//--- verilog/emc_pkg.sv
package emc_pkg;
   // Receive sequencer, one-hot
   typedef enum logic [3:0] {
      EMC_IDLE  = 4'h1,
      EMC_PRE   = 4'h2,
      EMC_DATA  = 4'h4,
      EMC_DRAIN = 4'h8
   } emc_rx_st_t;

   // Whole state of the status generator
   typedef struct packed {
      emc_rx_st_t  st;
      logic        clk_prev;
      logic [15:0] nib;
      logic [3:0]  lo;
      logic [15:0] lt;
      logic        vlan;
      logic        ipv4;
      logic [7:0]  hi;
      logic [15:0] sum;
      logic [5:0]  hlen;
      logic        lcol;
      logic        rx_watchdog_expired_flag;
      logic        rxer;
      logic [31:0] word0;
      logic        done;
      logic [6:0]  ctrl;
      logic [1:0]  ist;
      logic [1:0]  imask;
      logic [15:0] fcnt;
      logic [31:0] prdata;
      logic        irq;
   } emc_state_t;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] o;
   } emc_sync_t;

   typedef struct packed {
      logic [31:0] crc;
      logic        ok;
   } emc_crc_t;
endpackage

//--- verilog/emc_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module emc_sync3
   import emc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic [7:0] pin_i,
   output logic      [7:0] sync_o
);
   emc_sync_t q;   // Three stages plus agreed value
   emc_sync_t d;

   // Shift pins in; take a change once stages two and three agree
   always_comb begin
      d    = q;
      d.s1 = pin_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < 8; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.o[i] = q.s3[i];
         end
      end
   end

   // Register the state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.o;
endmodule
`default_nettype wire

//--- verilog/emc_crc32.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_params.svh"
module emc_crc32
   import emc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic       clear_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] byte_i,
   output logic            ok_o
);
   emc_crc_t q;   // Running remainder and residue match
   emc_crc_t d;

   // One byte through the reflected polynomial
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ `EMC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Frame check sequence included, so a good frame leaves the residue
   always_comb begin
      d = q;
      if (clear_i) begin
         d.crc = `EMC_CRC_INIT;
      end else if (valid_i) begin
         d.crc = crc_byte(q.crc, byte_i);
      end
      d.ok = (d.crc == `EMC_CRC_RESIDUE);
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q <= '{crc: `EMC_CRC_INIT, ok: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign ok_o = q.ok;
endmodule
`default_nettype wire

//--- verilog/emc_rx_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_params.svh"
module emc_rx_status
   import emc_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        srst_i,
   // Media-independent receive pins
   input  wire logic        phy_rx_clk_i,
   input  wire logic [3:0]  phy_rxd_i,
   input  wire logic        phy_rx_valid_input_i,
   input  wire logic        phy_rx_error_input_i,
   input  wire logic        phy_col_i,
   // Results from neighbouring receive logic, sampled at frame end
   input  wire logic        dest_filter_fail_flag_i,
   input  wire logic        da_match_nonzero_i,
   input  wire logic        ip_payload_err_i,
   input  wire logic        overflow_err_i,
   input  wire logic        descriptor_err_i,
   // Descriptor status towards the receive DMA
   output logic [31:0]      rx_descriptor_word0_o,
   output logic             status_valid_o,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o
);
   // Whole block state and its next value
   emc_state_t q;          // Registered state
   emc_state_t d;          // Next state
   // Link pins after the synchroniser
   logic [7:0] pins;       // Synchronised pins
   logic       s_clk;      // Link clock level
   logic [3:0] s_rxd;      // Link data nibble
   logic       s_dv;       // Link data valid
   logic       s_er;       // Link receive error
   logic       s_col;      // Link collision
   // Byte assembly and frame end strobes
   logic       rise;       // Link clock rising edge seen
   logic       byte_v;     // A byte completed this cycle
   logic [7:0] byte_d;     // The completed byte
   logic       crc_clr;    // Restart the check sequence
   logic       crc_ok;     // Check sequence residue matched
   logic       finish;     // Frame ends this cycle
   // Register bus and frame measures
   logic       wr;         // APB write in access phase
   logic [15:0] bidx;      // Index of the byte being formed
   logic [15:0] nbytes;    // Bytes received at frame end
   logic [15:0] glim;      // Giant threshold in force
   logic [15:0] wlim;      // Watchdog threshold in force
   logic [15:0] rel;       // Offset into the IPv4 header
   logic [5:0]  hl;        // Header length in force
   // Status terms, valid in the finish cycle
   logic        giant;     // Frame exceeded giant threshold
   logic        ip_bad;    // IPv4 header checksum failed
   logic        es;        // Error summary
   // Sticky interrupt status terms
   logic [1:0]  iset;      // Interrupt events this cycle
   logic [1:0]  iclr;      // Interrupt bits cleared by software

   // Register decode used only by the error answer; the read path decodes separately
   function automatic logic emc_hit(input logic [31:0] a);
      // Only the low address byte decodes; higher bits alias
      return (a[7:0] == `EMC_OFF_CTRL)  || (a[7:0] == `EMC_OFF_WORD0) ||
             (a[7:0] == `EMC_OFF_ISTAT) || (a[7:0] == `EMC_OFF_IMASK) ||
             (a[7:0] == `EMC_OFF_FCNT);
   endfunction

   // End-around carry add for the header checksum
   function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      // Carry out folds back into bit zero
      return s[15:0] + {15'h0000, s[16]};
   endfunction

   // Pins come from the link clock domain
   // Clock and data share one pipeline, so they stay aligned
   emc_sync3 u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .pin_i     ({phy_col_i, phy_rx_error_input_i, phy_rx_valid_input_i,
                   phy_rxd_i, phy_rx_clk_i}),
      .sync_o    (pins)
   );

   // Unpack in the order packed above
   assign s_clk = pins[0];
   assign s_rxd = pins[4:1];
   assign s_dv  = pins[5];
   assign s_er  = pins[6];
   assign s_col = pins[7];

   // Frame check sequence over every byte after the delimiter, up to a watchdog cut
   // Restarted at the delimiter, fed on every odd nibble
   emc_crc32 u_crc (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .clear_i   (crc_clr),
      .valid_i   (byte_v),
      .byte_i    (byte_d),
      .ok_o      (crc_ok)
   );

   // Thresholds follow the frame mode and the tag seen so far
   always_comb begin
      if (q.ctrl[`EMC_C_JUMBO]) begin
         // Jumbo mode lifts both limits
         glim = q.vlan ? `EMC_JUMBO_VLAN : `EMC_JUMBO_STD;
         wlim = `EMC_WDOG_JUMBO;
      end else begin
         // Normal mode; the extended bit widens only the giant limit
         wlim = `EMC_WDOG_STD;
         if (q.ctrl[`EMC_C_EXT2K]) begin
            glim = `EMC_GIANT_EXT;
         end else begin
            glim = q.vlan ? `EMC_GIANT_VLAN : `EMC_GIANT_STD;
         end
      end
   end

   // Receive sequencer, status latching and register file
   always_comb begin
      // Hold state by default; strobes idle
      d        = q;
      d.done   = 1'b0;
      d.clk_prev = s_clk;
      // Link clock edge, a few system cycles after the pin
      rise     = s_clk & ~q.clk_prev;
      byte_v   = 1'b0;
      byte_d   = {s_rxd, q.lo};
      crc_clr  = 1'b0;
      finish   = 1'b0;
      // Byte index from the nibble count
      bidx     = {1'b0, q.nib[15:1]};
      rel      = 16'h0000;
      hl       = q.hlen;
      case (q.st)
         // Wait for a preamble nibble
         // A disabled receiver ignores new frames
         EMC_IDLE: begin
            if (rise && s_dv && q.ctrl[`EMC_C_EN] && s_rxd == `EMC_NIB_PRE) begin
               d.st = EMC_PRE;
            end
         end
         // Look for the delimiter; clear the per-frame record
         EMC_PRE: begin
            if (rise) begin
               // Valid lost before the delimiter: silent abort
               if (!s_dv) begin
                  d.st = EMC_IDLE;
               end else if (s_rxd == `EMC_NIB_SFD) begin
                  d.st   = EMC_DATA;
                  d.nib  = 16'h0000;
                  d.lt   = 16'h0000;
                  d.vlan = 1'b0;
                  d.ipv4 = 1'b0;
                  d.sum  = 16'h0000;
                  d.hlen = 6'h00;
                  d.lcol = 1'b0;
                  d.rx_watchdog_expired_flag  = 1'b0;
                  d.rxer = 1'b0;
                  crc_clr = 1'b1;
               end
            end
         end
         // Collect nibbles into bytes and watch the line
         EMC_DATA: begin
            if (rise) begin
               // Valid low ends the frame; status goes out next cycle
               if (!s_dv) begin
                  finish = 1'b1;
                  d.st   = EMC_IDLE;
               end else begin
                  // Line error counts only while data is valid
                  if (s_er) begin
                     d.rxer = 1'b1;
                  end
                  // Collision past the slot time, half duplex only
                  if (s_col && q.ctrl[`EMC_C_HALF] && bidx >= `EMC_LATE_COL_BYTES) begin
                     d.lcol = 1'b1;
                  end
                  // Even nibble is the low half, odd completes the byte
                  if (!q.nib[0]) begin
                     d.lo = s_rxd;
                  end else begin
                     byte_v = 1'b1;
                  end
                  d.nib = q.nib + 16'h0001;
                  // Truncate at the timeout point, then wait out the line
                  if (bidx >= wlim) begin
                     d.rx_watchdog_expired_flag  = 1'b1;
                     finish = 1'b1;
                     // The cut byte never reaches the check sequence
                     byte_v = 1'b0;
                     d.st   = EMC_DRAIN;
                  end
               end
            end
         end
         // Discard the rest of a truncated frame
         // Next frame needs valid low first
         EMC_DRAIN: begin
            if (rise && !s_dv) begin
               d.st = EMC_IDLE;
            end
         end
         // Any stray code recovers to idle
         default: begin
            d.st = EMC_IDLE;
         end
      endcase

      // Header fields from completed bytes
      // Type sits at bytes 12-13, or four bytes later behind a tag
      if (byte_v) begin
         if (bidx == `EMC_LT_POS) begin
            d.lt[15:8] = byte_d;
         end
         if (bidx == `EMC_LT_POS + 16'h0001) begin
            d.lt[7:0] = byte_d;
            d.vlan = ({q.lt[15:8], byte_d} == `EMC_TPID_VLAN);
            d.ipv4 = ({q.lt[15:8], byte_d} == `EMC_TYPE_IPV4);
         end
         if (q.vlan && bidx == `EMC_VLAN_LT_POS) begin
            d.lt[15:8] = byte_d;
         end
         if (q.vlan && bidx == `EMC_VLAN_LT_POS + 16'h0001) begin
            d.lt[7:0] = byte_d;
            d.ipv4 = ({q.lt[15:8], byte_d} == `EMC_TYPE_IPV4);
         end
         // Sum the IPv4 header; other frames are never checked
         rel = bidx - (q.vlan ? `EMC_IP_POS_VLAN : `EMC_IP_POS);
         if (q.ipv4 && bidx >= (q.vlan ? `EMC_IP_POS_VLAN : `EMC_IP_POS)) begin
            // First header byte carries the header length in words
            if (rel == 16'h0000) begin
               hl = {byte_d[3:0], 2'b00};
               d.hlen = hl;
            end
            if (rel < {10'h000, hl}) begin
               // Even offsets hold the high byte of each word
               if (!rel[0]) begin
                  d.hi = byte_d;
               end else begin
                  d.sum = ones_add(q.sum, {q.hi, byte_d});
               end
            end
         end
      end

      // Compose the status word from everything latched
      // Neighbour inputs count only in the finish cycle
      nbytes = {1'b0, d.nib[15:1]};
      giant  = nbytes > glim;
      ip_bad = d.ipv4 && (d.sum != 16'hffff);
      es     = ~crc_ok | d.rxer | d.rx_watchdog_expired_flag | d.lcol | giant |
               ip_bad | ip_payload_err_i | overflow_err_i |
               descriptor_err_i;
      if (finish) begin
         d.done  = 1'b1;
         // Written whole, so the DMA never sees a mix of frames
         d.word0 = 32'h00000000;
         d.word0[`EMC_B_GIANT] = giant |
            (q.ctrl[`EMC_C_CSUM1] & ip_bad);
         d.word0[`EMC_B_LCOL]  = d.lcol;
         // Below the runt size the type bit is left clear
         d.word0[`EMC_B_FT]    = (nbytes >= `EMC_RUNT_BYTES) &&
            (d.lt >= `EMC_ETYPE_MIN);
         d.word0[`EMC_B_RWT]   = d.rx_watchdog_expired_flag;
         d.word0[`EMC_B_RXER]  = d.rxer;
         d.word0[`EMC_B_ODD]   = q.ctrl[`EMC_C_NIBBLE] & d.nib[0];
         d.word0[`EMC_B_CRC]   = ~crc_ok;
         // Extended status is offered when the features exist or the address match is nonzero, unless the filter failed
         d.word0[`EMC_B_XST]   = (q.ctrl[`EMC_C_XFEAT] | da_match_nonzero_i) &
            ~dest_filter_fail_flag_i;
         d.word0[`EMC_B_LAST]  = 1'b1;
         d.word0[`EMC_B_ES]    = es;
         d.word0[`EMC_B_AFM]   = dest_filter_fail_flag_i;
         // Frame counter wraps silently at 16 bits
         d.fcnt = q.fcnt + 16'h0001;
      end

      // APB writes take effect in the access phase
      wr   = psel_i & penable_i & pwrite_i;
      // Read-only and unmapped offsets drop the write
      iclr = 2'b00;
      if (wr) begin
         case (paddr_i[7:0])
            `EMC_OFF_CTRL:  d.ctrl  = pwdata_i[6:0];
            `EMC_OFF_ISTAT: iclr    = pwdata_i[1:0];
            `EMC_OFF_IMASK: d.imask = pwdata_i[1:0];
            default:        d.imask = d.imask;
         endcase
      end
      // Sticky events; a new event beats a clear in the same cycle
      iset  = {finish & es, finish};
      d.ist = (q.ist & ~iclr) | iset;
      // Level output, registered together with the status
      d.irq = |(d.ist & d.imask);

      // Read data is captured in setup so it stands in the access phase
      // Reads have no side effects; the status word stays
      if (psel_i && !penable_i && !pwrite_i) begin
         case (paddr_i[7:0])
            `EMC_OFF_CTRL:  d.prdata = {25'h0000000, q.ctrl};
            `EMC_OFF_WORD0: d.prdata = q.word0;
            `EMC_OFF_ISTAT: d.prdata = {30'h00000000, q.ist};
            `EMC_OFF_IMASK: d.prdata = {30'h00000000, q.imask};
            `EMC_OFF_FCNT:  d.prdata = {16'h0000, q.fcnt};
            default:        d.prdata = 32'h00000000;
         endcase
      end
   end

   // Register the state
   // Synchronous reset; all fields to known values
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q       <= '0;
         q.st    <= EMC_IDLE;
         // Receiver enabled in nibble mode out of reset
         q.ctrl  <= `EMC_CTRL_RST;
         q.ist   <= `EMC_IRQ_RST;
         q.imask <= `EMC_IRQ_RST;
      end else begin
         q <= d;
      end
   end

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~emc_hit(paddr_i);
   // Data outputs come straight from flip-flops
   assign prdata_o  = q.prdata;
   assign irq_o     = q.irq;
   assign rx_descriptor_word0_o = q.word0;
   assign status_valid_o        = q.done;
endmodule
`default_nettype wire

//--- tb/emc_rx_status_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module emc_rx_status_assertions
   import emc_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        srst_i,
   input wire logic        phy_rx_valid_input_i,
   input wire logic        phy_rx_error_input_i,
   input wire logic        dest_filter_fail_flag_i,
   input wire logic        ip_payload_err_i,
   input wire logic        overflow_err_i,
   input wire logic        descriptor_err_i,
   input wire logic [31:0] rx_descriptor_word0_o,
   input wire logic        status_valid_o,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [31:0] paddr_i,
   input wire logic        pslverr_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic [31:0] w;         // Short alias of the status word
   logic        er_seen_q; // Line error seen since last publish
   assign w = rx_descriptor_word0_o;
   // Sticky record, dropped once the status goes out
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || status_valid_o) er_seen_q <= 1'b0;
      else if (phy_rx_error_input_i && phy_rx_valid_input_i) er_seen_q <= 1'b1;
   end
   last_bit_a: assert property (status_valid_o |-> w[8])
      else $error("last descriptor bit missing");
   valid_pulse_a: assert property (status_valid_o |=> !status_valid_o)
      else $error("status valid longer than one cycle");
   word_hold_a: assert property (!status_valid_o |-> $stable(w))
      else $error("status word changed without valid");
   err_sum_a: assert property (status_valid_o |->
      w[15] == (w[1] | w[3] | w[4] | w[6] | w[7] |
      $past(ip_payload_err_i | overflow_err_i | descriptor_err_i)))
      else $error("error summary wrong");
   filt_fail_a: assert property (status_valid_o |->
      w[30] == $past(dest_filter_fail_flag_i)) else $error("filter fail bit wrong");
   xst_inval_a: assert property (status_valid_o && w[30] |-> !w[0])
      else $error("bit 0 set with filter fail");
   rx_err_a: assert property (status_valid_o |-> w[3] == er_seen_q)
      else $error("line error bit wrong");
   apb_err_a: assert property (psel_i && penable_i |->
      pslverr_o == !(paddr_i[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
      else $error("slave error wrong");
   crc_seen_c: cover property (status_valid_o && w[1]);
   giant_seen_c: cover property (status_valid_o && w[7]);
   irq_rise_c: cover property ($rose(irq_o));
endmodule
bind emc_rx_status emc_rx_status_assertions u_emc_rx_status_assertions (.*);
`default_nettype wire

//--- tb/emc_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module emc_phy_model (
   output logic       rx_clk_o,
   output logic [3:0] rxd_o,
   output logic       dv_o,
   output logic       er_o,
   output logic       col_o
);
   // Idle line, clock parked low outside frames
   initial begin
      rx_clk_o = 1'b0;
      rxd_o = 4'ha;
      dv_o = 1'b0;
      er_o = 1'b0;
      col_o = 1'b0;
   end
   // One link cycle; lines move while the clock is low
   task automatic nib(input logic [3:0] d, input logic v, e, c);
      rxd_o = v ? d : ~rxd_o; // Released data toggles, never holds
      dv_o = v;
      er_o = e;
      col_o = c;
      #80 rx_clk_o = 1'b1;
      #80 rx_clk_o = 1'b0;
   endtask
   // Whole frame of n bytes, check sequence included
   task automatic send(input int n, input logic [15:0] typ, input logic bad, odd,
                       input int er_at, col_at);
      logic [7:0]  b [$];
      logic [31:0] crc;
      crc = 32'hffffffff;
      for (int i = 0; i < n - 4; i++) begin
         b.push_back(i == 12 ? typ[15:8] : (i == 13 ? typ[7:0] : i[7:0]));
         crc = crc ^ {24'h0, b[i]};
         for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
      end
      crc = ~crc ^ {31'h0, bad};
      for (int i = 0; i < 4; i++) b.push_back(crc[8*i +: 8]);
      repeat (15) nib(4'h5, 1'b1, 1'b0, 1'b0);
      nib(4'hd, 1'b1, 1'b0, 1'b0);
      // Low nibble first; error and collision held a whole byte
      foreach (b[i]) begin
         nib(b[i][3:0], 1'b1, i == er_at, i == col_at);
         nib(b[i][7:4], 1'b1, i == er_at, i == col_at);
      end
      if (odd) nib(4'h3, 1'b1, 1'b0, 1'b0);
      repeat (4) nib(4'h0, 1'b0, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk_sys_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        rx_clk, dv, er, col; // Link pins from the model
   logic [3:0]  rxd;
   logic        filt_fail = 1'b0;    // Side inputs held through a frame
   logic        da_nz = 1'b0;
   logic [2:0]  extra = 3'h0;        // Payload, overflow, descriptor
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] word0, prdata, r;
   logic        svalid, pready, pslverr, irq, e;
   int          bad_count = 0;
   int          n_compared = 0;
   int          frames = 0;
   emc_rx_status u_emc_rx_status (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .phy_rx_clk_i(rx_clk), .phy_rxd_i(rxd),
      .phy_rx_valid_input_i(dv), .phy_rx_error_input_i(er), .phy_col_i(col),
      .dest_filter_fail_flag_i(filt_fail), .da_match_nonzero_i(da_nz),
      .ip_payload_err_i(extra[0]), .overflow_err_i(extra[1]), .descriptor_err_i(extra[2]),
      .rx_descriptor_word0_o(word0), .status_valid_o(svalid), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
   emc_phy_model u_emc_phy_model (
      .rx_clk_o(rx_clk), .rxd_o(rxd), .dv_o(dv), .er_o(er), .col_o(col));
   task automatic chk(input string name, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer; waits for pready, takes data at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(n, r, exp);
   endtask
   task automatic side(input logic f, z, input logic [2:0] x);
      @(posedge clk_sys_i);
      filt_fail <= f;
      da_nz <= z;
      extra <= x;
   endtask
   // Frame on the link while watching for the status pulse
   task automatic frame(input int n, input logic [15:0] typ, input logic bad, odd,
                        input int er_at, col_at, input logic [31:0] exp);
      int t;
      frames++;
      fork
         u_emc_phy_model.send(n, typ, bad, odd, er_at, col_at);
         begin
            t = 0;
            while (svalid !== 1'b1 && t < 40000) begin
               @(negedge clk_sys_i);
               t++;
            end
            if (t >= 40000) begin
               bad_count++;
               finish_test;
            end else begin
               chk("status word", word0, exp);
            end
         end
      join
   endtask
   task automatic t_regs;
      rd("ctrl", 8'h00, 32'h48);
      rd("istat", 8'h08, 32'h0);
      rd("imask", 8'h0c, 32'h0);
      rd("word0", 8'h04, 32'h0);
      rd("unmapped", 8'h20, 32'h0);
      chk("slave error", {31'h0, e}, 32'h1);
   endtask
   // Type boundary and address match report
   task automatic t_type;
      side(1'b0, 1'b1, 3'h0);
      frame(64, 16'h0600, 1'b0, 1'b0, -1, -1, 32'h121);
      side(1'b0, 1'b0, 3'h0);
      frame(64, 16'h05ff, 1'b0, 1'b0, -1, -1, 32'h100);
   endtask
   task automatic t_errors;
      side(1'b1, 1'b1, 3'h0);
      frame(64, 16'h0600, 1'b1, 1'b1, -1, -1, 32'h40008126);
      side(1'b0, 1'b0, 3'h0);
      frame(64, 16'h0600, 1'b0, 1'b0, 20, -1, 32'h8128);
      // Each neighbouring error alone
      for (int k = 0; k < 3; k++) begin
         side(1'b0, 1'b0, 3'h1 << k);
         frame(64, 16'h0600, 1'b0, 1'b0, -1, -1, 32'h8120);
      end
      side(1'b0, 1'b0, 3'h0);
   endtask
   task automatic t_irq;
      rd("istat", 8'h08, 32'h3);
      rd("fcnt", 8'h10, frames);
      apb(1'b1, 8'h0c, 32'h2);
      repeat (2) @(negedge clk_sys_i);
      chk("irq masked in", {31'h0, irq}, 32'h1);
      apb(1'b1, 8'h08, 32'h2);
      repeat (2) @(negedge clk_sys_i);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      rd("istat", 8'h08, 32'h1);
   endtask
   // Half duplex: late collision flagged, early one not
   task automatic t_lcol;
      apb(1'b1, 8'h00, 32'h4c);
      frame(80, 16'h0600, 1'b0, 1'b0, -1, 70, 32'h8160);
      frame(80, 16'h0600, 1'b0, 1'b0, -1, 10, 32'h120);
      apb(1'b1, 8'h00, 32'h68);
   endtask
   // One byte over the standard limit, extended features on; then the 2000 limit
   task automatic t_giant;
      frame(1519, 16'h0600, 1'b0, 1'b0, -1, -1, 32'h81a1);
      apb(1'b1, 8'h00, 32'h6a);
      frame(1519, 16'h0600, 1'b0, 1'b0, -1, -1, 32'h121);
   endtask
   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Free-running system clock
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      t_regs;
      t_type;
      t_errors;
      t_irq;
      t_lcol;
      t_giant;
      finish_test;
   end
   // Hang guard, well beyond the expected run
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      bad_count++;
      finish_test;
   end
endmodule
`default_nettype wire
